// [src/lpcfg_cell.sv]
// Purpose: One recovery cell, running as repeater or as retimer with an add/drop buffer.
// Assumes: rx.valid marks a word on the recovered clock; bit_tick marks a local bit clock word slot.
// Notes:   DEPTH must be a power of two so the pointers wrap on their own.
`timescale 1ns/100ps
module lpcfg_cell #(
  parameter int                       W     = lpcfg_pkg::WORD_W,
  parameter int                       DEPTH = lpcfg_pkg::FIFO_DEPTH,
  parameter logic [lpcfg_pkg::WORD_W-1:0] FILL = lpcfg_pkg::FILL_WORD
) (
  input  wire logic      clk,
  input  wire logic      rst_n,
  input  wire logic      mode_sel,
  input  wire logic      relock,
  input  wire logic      bit_tick,
  lpcfg_stream_if.snk    rx,
  lpcfg_stream_if.src    tx,
  output logic           ins_evt,
  output logic           drop_evt
);
  import lpcfg_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wptr, next_wptr, rptr, next_rptr;
  logic [CW-1:0] fill, next_fill;
  logic [W-1:0]  dout, next_dout;
  logic          vout, next_vout, next_ins, next_drop;
  logic          push, pop;

  // Next state of the cell; a relock empties the buffer so stale words are not sent after a path change.
  always_comb begin
    next_wptr = wptr;
    next_rptr = rptr;
    next_fill = fill;
    next_dout = dout;
    next_vout = 1'b0;
    next_ins  = 1'b0;
    next_drop = 1'b0;
    push      = 1'b0;
    pop       = 1'b0;
    if (relock) begin                                                    // [RQ19]
      next_wptr = '0;
      next_rptr = '0;
      next_fill = '0;
    end else if (mode_sel) begin
      // Repeater: the word leaves on the recovered clock strobe itself.
      if (rx.valid) begin                                                // [RQ14] [RQ16]
        next_dout = rx.data;
        next_vout = 1'b1;
      end
    end else begin
      // Retimer: words leave only on the local bit clock slot.
      pop = bit_tick && (fill != '0);                                    // [RQ18]
      if (bit_tick && (fill == '0)) begin
        next_dout = FILL;                                                // [RQ18]
        next_vout = 1'b1;
        next_ins  = 1'b1;
      end
      if (pop) begin
        next_dout = mem[rptr];
        next_vout = 1'b1;
        next_rptr = AW'(rptr + 1'b1);
      end
      // With no pop in the same cycle, a fill word is dropped to keep one slot of headroom and a full buffer loses the word.
      if (rx.valid) begin
        if ((fill == CW'(DEPTH)) && !pop) begin
          next_drop = 1'b1;
        end else if ((rx.data == FILL) && (fill >= CW'(DEPTH - 1)) && !pop) begin
          next_drop = 1'b1;                                              // [RQ18]
        end else begin
          push      = 1'b1;
          next_wptr = AW'(wptr + 1'b1);
        end
      end
      next_fill = CW'(fill + {{(CW-1){1'b0}}, push} - {{(CW-1){1'b0}}, pop});
    end
  end

  // State registers of the cell.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wptr     <= '0;
      rptr     <= '0;
      fill     <= '0;
      dout     <= '0;
      vout     <= 1'b0;
      ins_evt  <= 1'b0;
      drop_evt <= 1'b0;
    end else begin
      wptr     <= next_wptr;
      rptr     <= next_rptr;
      fill     <= next_fill;
      dout     <= next_dout;
      vout     <= next_vout;
      ins_evt  <= next_ins;
      drop_evt <= next_drop;
    end
  end

  // Buffer storage needs no reset; fill guards every read.
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wptr] <= rx.data;
    end
  end

  assign tx.data  = dout;
  assign tx.valid = vout;
endmodule : lpcfg_cell

// [src/lpcfg_pkg.sv]
// Purpose: Shared constants for the loop path configuration and clocking block.
// Assumes: APB register access with 32-bit data; serial traffic modelled as words with a valid strobe.
// Notes:   Offsets are byte addresses; field positions index the 32-bit register word.
package lpcfg_pkg;

  // Register byte offsets.
  localparam logic [11:0] OFF_CTRL      = 12'h000;
  localparam logic [11:0] OFF_DRIVE_EN  = 12'h004;
  localparam logic [11:0] OFF_STATUS    = 12'h008;
  localparam logic [11:0] OFF_CELL_STAT = 12'h00c;

  // Control register field positions.
  localparam int CTRL_REF_RATIO   = 0;
  localparam int CTRL_RATE_ONE    = 1;
  localparam int CTRL_RATE_TWO    = 2;
  localparam int CTRL_RETURN_PATH = 3;
  localparam int CTRL_FIRST_FEED  = 4;
  localparam int CTRL_C2_INPUT    = 5;
  localparam int CTRL_C1_INPUT    = 6;
  localparam int CTRL_C1_MODE     = 7;
  localparam int CTRL_C2_MODE     = 8;
  localparam int CTRL_HOST_EMPH   = 9;
  localparam int CTRL_PORT_EMPH   = 10;
  localparam int CTRL_BYPASS_LSB  = 16;
  localparam int NUM_PORTS        = 6;

  // Bits of the control word that disturb the recovery cells when they change, then the bits that a write can set.
  localparam logic [31:0] CTRL_PATH_MASK = 32'h0000_01f8;
  localparam logic [31:0] CTRL_WR_MASK   = 32'h003f_07ff;

  // Status register field positions.
  localparam int STAT_RATIO_LSB  = 0;
  localparam int STAT_PORT_PWR   = 8;
  localparam int STAT_HOST_A_PWR = 16;
  localparam int STAT_HOST_B_PWR = 17;
  localparam int STAT_HOST_EMPH  = 18;
  localparam int STAT_PORT_EMPH  = 19;
  localparam int STAT_DRIVE_LSB  = 24;

  // Cell status sticky bits.
  localparam int CST_C1_INS  = 0;
  localparam int CST_C1_DROP = 1;
  localparam int CST_C2_INS  = 2;
  localparam int CST_C2_DROP = 3;

  // Reset values; the multiplier starts in its 20x setting.
  localparam logic [31:0] CTRL_RESET     = 32'h0000_0001;
  localparam logic [7:0]  DRIVE_EN_RESET = 8'h00;

  // Multiplier ratios and the bit clock they reach.
  localparam logic [5:0] RATIO_HIGH_REF = 6'h14;
  localparam logic [5:0] RATIO_LOW_REF  = 6'h28;
  localparam real        BIT_CLK_GHZ    = 2.125;

  // Stream word and elastic buffer shape.
  localparam int          WORD_W     = 40;
  localparam int          FIFO_DEPTH = 4;
  localparam logic [39:0] FILL_WORD  = 40'h00_0000_0000;

endpackage

// [src/lpcfg_stream_if.sv]
// Purpose: Word stream carrier between the configuration core and a recovery cell.
// Assumes: One word moves in each cycle that valid is high.
// Notes:   No back-pressure; a serial loop cannot be stalled.
`timescale 1ns/100ps
interface lpcfg_stream_if #(parameter int W = 40);
  logic [W-1:0] data;
  logic         valid;
  modport src (output data, output valid);
  modport snk (input data, input valid);
endinterface : lpcfg_stream_if

// [src/lpcfg_top.sv]
// Purpose: Configuration, routing and clocking control of a hex loop bypass device, with an APB register file.
// Assumes: All pins synchronous to pclk; ref_clk_in is sampled, serial streams arrive as words.
// Notes:   Control bits are meant to be static; any path change relocks both recovery cells.
//
// How it works
// [RQ1] Multiplier ratio is 20 with ref_ratio_sel high, 40 when low, giving 2.125GHz.
// [RQ2] Board supplies 106.25MHz for the high setting, 53.125MHz for the low setting.
// [RQ3] Reference and ratio setting stay independent of both rate select bits.
// [RQ4] Integrators should keep ref_ratio_sel high; the 40x setting may miss jitter limits.
// [RQ5] Only rising edges of ref_clk_in produce bit clock slots.
// [RQ6] A drive port input buffer is powered only while its bypass select is high.
// [RQ7] host_in_a powered with cell_one_input_sel, host_in_b with cell_two_input_sel.
// [RQ8] return_mux picks bypass stage six or cell two; feeds host_out_a, feed_mux, cell_one_mux.
// [RQ9] feed_mux picks return_mux or cell one and drives bypass stage one.
// [RQ10] cell_two_mux picks bypass stage six or host_in_b for cell two.
// [RQ11] cell_one_mux picks return_mux or host_in_a for cell one.
// [RQ12] Each output driver is off while its drive enable is low.
// [RQ13] Pre-emphasis off when its disable bit is high: host pair and six port outputs.
// [RQ14] Each cell repeats when its mode select is high and retimes when low.
// [RQ15] Cell one runs from cell_one_mux to feed_mux; cell two from cell_two_mux to return_mux.
// [RQ16] A repeater resends data on the recovered clock, not the local bit clock.
// [RQ17] Ten drive cascade: cell two input low, cell one input high, others per case.
// [RQ18] A retimer passes data through a four word add/drop buffer to the bit clock.
// [RQ19] Controls are static; changing them relocks the cells and may corrupt traffic. Here only a change of the path bits 3 to 8 relocks.
`timescale 1ns/100ps
module lpcfg_top
  import lpcfg_pkg::*;
#(
  parameter int W = lpcfg_pkg::WORD_W
) (
  input  wire logic                           pclk,
  input  wire logic                           presetn,
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [11:0]                    paddr,
  input  wire logic [31:0]                    pwdata,
  output logic [31:0]                         prdata,
  output logic                                pready,
  output logic                                pslverr,
  input  wire logic                           ref_clk_in,
  input  wire logic [W-1:0]                   host_in_a_data,
  input  wire logic                           host_in_a_valid,
  input  wire logic [W-1:0]                   host_in_b_data,
  input  wire logic                           host_in_b_valid,
  input  wire logic [W-1:0]                   bypass_stage_six_data,
  input  wire logic                           bypass_stage_six_valid,
  output logic [W-1:0]                        bypass_stage_one_data,
  output logic                                bypass_stage_one_valid,
  output logic [W-1:0]                        host_out_a_data,
  output logic                                host_out_a_valid,
  output logic [W-1:0]                        host_out_b_data,
  output logic                                host_out_b_valid,
  output logic [lpcfg_pkg::NUM_PORTS-1:0]     port_in_power,
  output logic                                host_in_a_power,
  output logic                                host_in_b_power,
  output logic [7:0]                          drive_power,
  output logic                                host_emph_on,
  output logic                                port_emph_on,
  output logic [5:0]                          mult_ratio,
  output logic                                bit_tick
);
  import lpcfg_pkg::*;

  logic [31:0]          ctrl, next_ctrl;
  logic [7:0]           drive_en, next_drive_en;
  logic [3:0]           cell_stat, next_cell_stat;
  logic [31:0]          next_prdata;
  logic                 relock, next_relock;
  logic                 ref_q;
  logic [W-1:0]         out_a_d, next_out_a_d, out_b_d, next_out_b_d, stage_one_d, next_stage_one_d;
  logic                 out_a_v, next_out_a_v, out_b_v, next_out_b_v, stage_one_v, next_stage_one_v;
  logic                 wr_en, rd_setup, addr_hit;
  logic [31:0]          status;
  logic [W-1:0]         ret_d, feed_d;
  logic                 ret_v, feed_v;
  logic                 c1_ins, c1_drop, c2_ins, c2_drop;
  logic                 ratio_sel, ret_sel, feed_sel, c2_in_sel, c1_in_sel;
  logic [NUM_PORTS-1:0] bypass_sel;

  lpcfg_stream_if #(.W(W)) c1_rx ();
  lpcfg_stream_if #(.W(W)) c1_tx ();
  lpcfg_stream_if #(.W(W)) c2_rx ();
  lpcfg_stream_if #(.W(W)) c2_tx ();

  // Named views of the control word.
  assign ratio_sel  = ctrl[CTRL_REF_RATIO];
  assign ret_sel    = ctrl[CTRL_RETURN_PATH];
  assign feed_sel   = ctrl[CTRL_FIRST_FEED];
  assign c2_in_sel  = ctrl[CTRL_C2_INPUT];
  assign c1_in_sel  = ctrl[CTRL_C1_INPUT];
  assign bypass_sel = ctrl[CTRL_BYPASS_LSB +: NUM_PORTS];

  // The ratio follows ref_ratio_sel alone; the rate select bits are stored but never looked at here.
  assign mult_ratio = ratio_sel ? RATIO_HIGH_REF : RATIO_LOW_REF;        // [RQ1] [RQ3]

  // A falling reference edge carries no timing, so duty cycle distortion cannot add slots.
  assign bit_tick = ref_clk_in & ~ref_q;                                 // [RQ5]

  // Power and pre-emphasis controls seen by the analog side.
  assign port_in_power   = bypass_sel;                                   // [RQ6]
  assign host_in_a_power = c1_in_sel;                                    // [RQ7]
  assign host_in_b_power = c2_in_sel;                                    // [RQ7] [RQ17]
  assign drive_power     = drive_en;                                     // [RQ12]
  assign host_emph_on    = ~ctrl[CTRL_HOST_EMPH];                        // [RQ13]
  assign port_emph_on    = ~ctrl[CTRL_PORT_EMPH];                        // [RQ13]

  // Return path selects bypass stage six or the output of cell two.
  assign ret_d = ret_sel ? c2_tx.data  : bypass_stage_six_data;          // [RQ8] [RQ15]
  assign ret_v = ret_sel ? c2_tx.valid : bypass_stage_six_valid;         // [RQ8]

  // Feed into bypass stage one selects the return path or cell one.
  assign feed_d = feed_sel ? c1_tx.data  : ret_d;                        // [RQ9] [RQ15]
  assign feed_v = feed_sel ? c1_tx.valid : ret_v;                        // [RQ9]

  // Cell inputs; an unpowered host input contributes no words.
  assign c2_rx.data  = c2_in_sel ? host_in_b_data : bypass_stage_six_data;                 // [RQ10] [RQ15]
  assign c2_rx.valid = c2_in_sel ? host_in_b_valid : bypass_stage_six_valid;               // [RQ10]
  assign c1_rx.data  = c1_in_sel ? host_in_a_data : ret_d;                                 // [RQ11] [RQ15]
  assign c1_rx.valid = c1_in_sel ? host_in_a_valid : ret_v;                                // [RQ11] [RQ7]

  lpcfg_cell #(.W(W), .DEPTH(FIFO_DEPTH), .FILL(FILL_WORD)) u_cell_one (
    .clk      (pclk),
    .rst_n    (presetn),
    .mode_sel (ctrl[CTRL_C1_MODE]),
    .relock   (relock),
    .bit_tick (bit_tick),
    .rx       (c1_rx),
    .tx       (c1_tx),
    .ins_evt  (c1_ins),
    .drop_evt (c1_drop)
  );

  lpcfg_cell #(.W(W), .DEPTH(FIFO_DEPTH), .FILL(FILL_WORD)) u_cell_two (
    .clk      (pclk),
    .rst_n    (presetn),
    .mode_sel (ctrl[CTRL_C2_MODE]),
    .relock   (relock),
    .bit_tick (bit_tick),
    .rx       (c2_rx),
    .tx       (c2_tx),
    .ins_evt  (c2_ins),
    .drop_evt (c2_drop)
  );

  // APB decode; the slave never inserts wait states.
  assign wr_en    = psel & penable & pwrite;
  assign rd_setup = psel & ~penable;
  assign addr_hit = (paddr == OFF_CTRL) || (paddr == OFF_DRIVE_EN) ||
                    (paddr == OFF_STATUS) || (paddr == OFF_CELL_STAT);
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~addr_hit;

  // Status word shows the live power, emphasis and ratio state.
  always_comb begin
    status = 32'h0000_0000;
    status[STAT_RATIO_LSB +: 6]        = mult_ratio;
    status[STAT_PORT_PWR +: NUM_PORTS] = port_in_power;
    status[STAT_HOST_A_PWR]            = host_in_a_power;
    status[STAT_HOST_B_PWR]            = host_in_b_power;
    status[STAT_HOST_EMPH]             = host_emph_on;
    status[STAT_PORT_EMPH]             = port_emph_on;
    status[STAT_DRIVE_LSB +: 8]        = drive_power;
  end

  // Register file next state; read data is fetched in the setup cycle so it stands through the access.
  always_comb begin
    next_ctrl      = ctrl;
    next_drive_en  = drive_en;
    next_relock    = 1'b0;
    next_prdata    = prdata;
    next_cell_stat = cell_stat;
    if (wr_en && (paddr == OFF_CTRL)) begin
      next_ctrl   = pwdata & CTRL_WR_MASK;
      next_relock = |((ctrl ^ pwdata) & CTRL_PATH_MASK);                // [RQ19]
    end
    if (wr_en && (paddr == OFF_DRIVE_EN)) begin
      next_drive_en = pwdata[7:0];
    end
    if (wr_en && (paddr == OFF_CELL_STAT)) begin
      next_cell_stat = cell_stat & ~pwdata[3:0];
    end
    // Hardware set comes last so an event in the clearing cycle survives.
    next_cell_stat[CST_C1_INS]  = next_cell_stat[CST_C1_INS]  | c1_ins;   // [RQ18]
    next_cell_stat[CST_C1_DROP] = next_cell_stat[CST_C1_DROP] | c1_drop;  // [RQ18]
    next_cell_stat[CST_C2_INS]  = next_cell_stat[CST_C2_INS]  | c2_ins;   // [RQ18]
    next_cell_stat[CST_C2_DROP] = next_cell_stat[CST_C2_DROP] | c2_drop;  // [RQ18]
    if (rd_setup) begin
      case (paddr)
        OFF_CTRL:      next_prdata = ctrl;
        OFF_DRIVE_EN:  next_prdata = {24'h00_0000, drive_en};
        OFF_STATUS:    next_prdata = status;
        OFF_CELL_STAT: next_prdata = {28'h000_0000, cell_stat};
        default:       next_prdata = 32'h0000_0000;
      endcase
    end
  end

  // Register file flip-flops.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl      <= CTRL_RESET;
      drive_en  <= DRIVE_EN_RESET;
      cell_stat <= 4'h0;
      relock    <= 1'b0;
      prdata    <= 32'h0000_0000;
      ref_q     <= 1'b0;
    end else begin
      ctrl      <= next_ctrl;
      drive_en  <= next_drive_en;
      cell_stat <= next_cell_stat;
      relock    <= next_relock;
      prdata    <= next_prdata;
      ref_q     <= ref_clk_in;
    end
  end

  // Output stage; a powered-down driver sends nothing rather than stale data.
  always_comb begin
    next_out_a_d     = out_a_d;
    next_out_b_d     = out_b_d;
    next_stage_one_d = feed_d;                                           // [RQ9]
    next_stage_one_v = feed_v;
    next_out_a_v     = 1'b0;
    next_out_b_v     = 1'b0;
    if (drive_en[0]) begin
      next_out_a_d = ret_d;                                              // [RQ8] [RQ12]
      next_out_a_v = ret_v;
    end
    if (drive_en[1]) begin
      next_out_b_d = c2_tx.data;                                         // [RQ12]
      next_out_b_v = c2_tx.valid;
    end
  end

  // Output stage flip-flops.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_a_d     <= '0;
      out_a_v     <= 1'b0;
      out_b_d     <= '0;
      out_b_v     <= 1'b0;
      stage_one_d <= '0;
      stage_one_v <= 1'b0;
    end else begin
      out_a_d     <= next_out_a_d;
      out_a_v     <= next_out_a_v;
      out_b_d     <= next_out_b_d;
      out_b_v     <= next_out_b_v;
      stage_one_d <= next_stage_one_d;
      stage_one_v <= next_stage_one_v;
    end
  end

  assign host_out_a_data        = out_a_d;
  assign host_out_a_valid       = out_a_v;
  assign host_out_b_data        = out_b_d;
  assign host_out_b_valid       = out_b_v;
  assign bypass_stage_one_data  = stage_one_d;
  assign bypass_stage_one_valid = stage_one_v;
endmodule : lpcfg_top

// [tb/lpcfg_loop_model.sv]
// Purpose: Loop ports and reference oscillator facing the block.
// Assumes: One word per send; lines idle between words.
// Notes:   Idle lines show a changing pattern, never the last word.
`timescale 1ns/100ps
module lpcfg_loop_model #(
  parameter int W = 40
) (
  input  logic         pclk,
  output logic         ref_clk_in,
  output logic [W-1:0] a_data,
  output logic         a_valid,
  output logic [W-1:0] b_data,
  output logic         b_valid,
  output logic [W-1:0] s_data,
  output logic         s_valid
);
  logic [1:0]   cnt = 2'h0;
  logic [2:0]   vld = 3'h0;
  logic [W-1:0] dat [3];
  logic [W-1:0] idle;
  // One fixed reference rate; its frequency is not visible at the ports.
  always @(posedge pclk) cnt <= cnt + 2'h1;
  assign ref_clk_in = cnt[1];
  assign idle       = {W{cnt[0]}} ^ {(W/8){8'h5a}};
  assign a_data     = vld[0] ? dat[0] : idle;
  assign b_data     = vld[1] ? dat[1] : idle;
  assign s_data     = vld[2] ? dat[2] : idle;
  assign {s_valid, b_valid, a_valid} = vld;
  // Quiet cycles first, so a preceding control change has settled.
  task automatic send(input int port, input logic [W-1:0] d);
    repeat (3) @(posedge pclk);
    dat[port] <= d;
    vld[port] <= 1'b1;
    @(posedge pclk);
    vld[port] <= 1'b0;
  endtask
endmodule // lpcfg_loop_model

// [tb/lpcfg_props.sv]
// Purpose: Concurrent checks on routing, power, emphasis and clock controls.
// Assumes: CTRL changes only through APB writes.
// Notes:   A shadow of CTRL mirrors the hidden register.
`timescale 1ns/100ps
module lpcfg_props
  import lpcfg_pkg::*;
#(
  parameter int W = 40
) (
  input logic         pclk,
  input logic         presetn,
  input logic         psel,
  input logic         penable,
  input logic         pwrite,
  input logic [11:0]  paddr,
  input logic [31:0]  pwdata,
  input logic         ref_clk_in,
  input logic [W-1:0] host_in_a_data,
  input logic         host_in_a_valid,
  input logic [W-1:0] bypass_stage_six_data,
  input logic         bypass_stage_six_valid,
  input logic [W-1:0] bypass_stage_one_data,
  input logic         bypass_stage_one_valid,
  input logic [W-1:0] host_out_a_data,
  input logic         host_out_a_valid,
  input logic         host_out_b_valid,
  input logic [5:0]   port_in_power,
  input logic         host_in_a_power,
  input logic         host_in_b_power,
  input logic [7:0]   drive_power,
  input logic         host_emph_on,
  input logic         port_emph_on,
  input logic [5:0]   mult_ratio,
  input logic         bit_tick
);
  logic [31:0] sh;
  logic [2:0]  quiet;
  logic        wr_c;
  logic        calm;
  assign wr_c = psel && penable && pwrite && paddr == OFF_CTRL;
  assign calm = quiet > 3'h2;
  // Streams are only judged once the relock after a CTRL write has passed.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh    <= CTRL_RESET;
      quiet <= 3'h7;
    end else if (wr_c) begin
      sh    <= pwdata & CTRL_WR_MASK;
      quiet <= 3'h0;
    end else if (quiet != 3'h7) begin
      quiet <= quiet + 3'h1;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_ctrl_wr;
    wr_c;
  endsequence
  sequence s_rep_one;
    calm && sh[CTRL_C1_INPUT] && sh[CTRL_C1_MODE] && sh[CTRL_FIRST_FEED] && host_in_a_valid;
  endsequence
  chk_ratio_set: assert property (s_ctrl_wr |=>
    mult_ratio == ($past(pwdata[0]) ? RATIO_HIGH_REF : RATIO_LOW_REF)) else $error("ratio wrong");
  chk_port_power: assert property (s_ctrl_wr |=> port_in_power == $past(pwdata[21:16]))
    else $error("port power wrong");
  chk_host_power: assert property (s_ctrl_wr |=>
    {host_in_a_power, host_in_b_power} == $past(pwdata[6:5])) else $error("host power wrong");
  chk_emph_level: assert property (s_ctrl_wr |=>
    host_emph_on == !$past(pwdata[9]) && port_emph_on == !$past(pwdata[10])) else $error("emphasis wrong");
  chk_drive_map: assert property (psel && penable && pwrite && paddr == OFF_DRIVE_EN |=>
    drive_power == $past(pwdata[7:0])) else $error("drive power wrong");
  chk_drive_gate: assert property (!drive_power[0] && !$past(drive_power[0]) |-> !host_out_a_valid)
    else $error("host out a sent while off");
  chk_tick_rise: assert property (bit_tick |-> ref_clk_in && !$past(ref_clk_in))
    else $error("tick without rising edge");
  chk_return_path: assert property (calm && !sh[CTRL_RETURN_PATH] && drive_power[0] &&
    bypass_stage_six_valid |=> host_out_a_valid && host_out_a_data == $past(bypass_stage_six_data))
    else $error("return path wrong");
  chk_repeat_feed: assert property (s_rep_one |-> ##2 bypass_stage_one_valid &&
    bypass_stage_one_data == $past(host_in_a_data, 2)) else $error("repeater feed wrong");
  chk_retime_slot: assert property (bit_tick && calm && !sh[CTRL_C2_MODE] && drive_power[1] |->
    ##2 host_out_b_valid) else $error("retimer slot empty");
endmodule // lpcfg_props

bind lpcfg_top lpcfg_props #(.W(W)) chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .ref_clk_in, .host_in_a_data, .host_in_a_valid, .bypass_stage_six_data, .bypass_stage_six_valid,
  .bypass_stage_one_data, .bypass_stage_one_valid, .host_out_a_data, .host_out_a_valid,
  .host_out_b_valid, .port_in_power, .host_in_a_power, .host_in_b_power, .drive_power,
  .host_emph_on, .port_emph_on, .mult_ratio, .bit_tick);

// [tb/tb.sv]
// Purpose: Register and stream path tests of the loop configuration block.
// Assumes: APB answers at once; streams come from the loop model.
// Notes:   Latencies are counted in pclk cycles.
`timescale 1ns/100ps
module tb;
  import lpcfg_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, ref_clk_in, tick;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, v;
  logic [39:0] a_d, b_d, s_d, one_d, oa_d, ob_d;
  logic        a_v, b_v, s_v, one_v, oa_v, ob_v, ha_p, hb_p, he, pe;
  logic [5:0]  pp, ratio;
  logic [7:0]  dp;
  int          num_errors = 0, checks = 0, cyc = 0;
  lpcfg_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .ref_clk_in, .host_in_a_data(a_d), .host_in_a_valid(a_v), .host_in_b_data(b_d),
    .host_in_b_valid(b_v), .bypass_stage_six_data(s_d), .bypass_stage_six_valid(s_v),
    .bypass_stage_one_data(one_d), .bypass_stage_one_valid(one_v), .host_out_a_data(oa_d),
    .host_out_a_valid(oa_v), .host_out_b_data(ob_d), .host_out_b_valid(ob_v), .port_in_power(pp),
    .host_in_a_power(ha_p), .host_in_b_power(hb_p), .drive_power(dp), .host_emph_on(he),
    .port_emph_on(pe), .mult_ratio(ratio), .bit_tick(tick));
  lpcfg_loop_model far_u (.pclk, .ref_clk_in, .a_data(a_d), .a_valid(a_v),
    .b_data(b_d), .b_valid(b_v), .s_data(s_d), .s_valid(s_v));
  always #20 pclk = ~pclk;
  task automatic complete_run();
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Cuts a hang short, far beyond the cycles the tests need.
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 4000) begin
      num_errors++;
      complete_run();
    end
  end
  task automatic chk(input logic [40:0] got, input logic [40:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Holds the request until pready is high at a rising edge.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  // Output 0 is bypass stage one, 1 host out a, 2 host out b.
  task automatic pass_word(input int port, input int out, input logic [39:0] d, input int lat);
    far_u.send(port, d);
    repeat (lat - 1) @(posedge pclk);
    #1;
    chk(out == 0 ? {one_v, one_d} : out == 1 ? {oa_v, oa_d} : {ob_v, ob_d}, {1'b1, d});
  endtask
  // Retimer words leave only on local slots, so they are awaited under a bound.
  task automatic await_b(input logic [39:0] d);
    for (int n = 0; n < 40 && !(ob_v === 1'b1 && ob_d === d); n++) begin
      @(posedge pclk);
      #1;
    end
    chk({ob_v, ob_d}, {1'b1, d});
  endtask
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, OFF_CTRL, 32'h0);
    chk(rd, CTRL_RESET);
    chk(ratio, RATIO_HIGH_REF);
    apb(0, OFF_DRIVE_EN, 32'h0);
    chk(rd, DRIVE_EN_RESET);
    // Ratio follows bit 0 alone, whatever the two rate selects hold.
    for (int i = 0; i < 8; i++) begin
      apb(1, OFF_CTRL, 32'(i));
      chk(ratio, i[0] ? RATIO_HIGH_REF : RATIO_LOW_REF);
    end
    // Power and emphasis follow their selects in two opposite patterns.
    for (int i = 0; i < 2; i++) begin
      v = i ? 32'h0015_0021 : 32'h002a_0641;
      apb(1, OFF_CTRL, v);
      chk(pp, v[21:16]);
      chk({ha_p, hb_p}, v[6:5]);
      chk({he, pe}, {~v[9], ~v[10]});
    end
    apb(1, OFF_CTRL, 32'h1);
    far_u.send(2, 40'h12_3456_789a);
    #1;
    chk(oa_v, 1'b0);
    apb(1, OFF_DRIVE_EN, 32'hff);
    apb(0, OFF_STATUS, 32'h0);
    chk(rd, 32'hff0c_0014);
    pass_word(2, 1, 40'h23_4567_89ab, 1);
    pass_word(2, 0, 40'h34_5678_9abc, 1);
    // Ten drive cascade: cell two input low, cell one input high and repeating; then cell two repeats from host_in_b and from stage six.
    apb(1, OFF_CTRL, 32'h0000_00d1);
    pass_word(0, 0, 40'h45_6789_abcd, 2);
    apb(1, OFF_CTRL, 32'h0000_0129);
    pass_word(1, 1, 40'h56_789a_bcde, 2);
    pass_word(1, 2, 40'h67_89ab_cdef, 2);
    apb(1, OFF_CTRL, 32'h0000_0109);
    pass_word(2, 2, 40'h78_9abc_def0, 2);
    // Both cells retime; an empty buffer sends fill words on local slots.
    apb(1, OFF_CTRL, 32'h1);
    await_b(FILL_WORD);
    apb(0, OFF_CELL_STAT, 32'h0);
    chk(rd[CST_C2_INS], 1'b1);
    far_u.send(2, 40'h89_abcd_ef01);
    await_b(40'h89_abcd_ef01);
    apb(0, 12'h010, 32'h0);
    chk({err, rd}, {1'b1, 32'h0});
    complete_run();
  end
endmodule // tb
